// ===== include/ssf_pkg.sv
package ssf_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the apb)
  // ----------------------------------------------------------------
  localparam int              SSF_AW         = 12;      // decoded address width
  localparam logic [11:0]     SSF_OFF_STATUS = 12'h000; // serial_status
  localparam logic [11:0]     SSF_OFF_TXBUF  = 12'h004; // tx_buffer_reg, write side
  localparam logic [11:0]     SSF_OFF_RXBUF  = 12'h008; // rx_buffer_reg, read side
  localparam logic [11:0]     SSF_OFF_CTRL   = 12'h00c; // serial_control subset

  // ----------------------------------------------------------------
  // serial_status field positions and reset value
  // ----------------------------------------------------------------
  localparam int              SSF_POS_TXE    = 7;       // tx_buffer_empty_flag
  localparam int              SSF_POS_RXF    = 6;       // rx_buffer_full_flag
  localparam int              SSF_POS_OVR    = 5;       // overrun_error_flag
  localparam int              SSF_POS_FRM    = 4;       // framing_error_flag
  localparam int              SSF_POS_PAR    = 3;       // parity_error_flag
  localparam int              SSF_POS_TRANSMIT_END_FLAG   = 2;       // transmit_end_flag
  localparam int              SSF_POS_RMP    = 1;       // rx_multiproc_bit
  localparam int              SSF_POS_TMP    = 0;       // tx_multiproc_bit
  localparam int              SSF_POS_FLAG0  = 3;       // lowest of the five clearable flags
  localparam int              SSF_NFLAGS     = 5;       // number of clearable flags
  localparam logic [7:0]      SSF_STATUS_RST = 8'h84;   // value after reset and standby

  // ----------------------------------------------------------------
  // control register field positions
  // ----------------------------------------------------------------
  localparam int              SSF_CTL_TE     = 0;       // transmitter_enable
  localparam int              SSF_CTL_RE     = 1;       // receiver_enable
  localparam int              SSF_CTL_SYNC   = 2;       // clocked synchronous mode
  localparam int              SSF_CTL_PAREN  = 3;       // parity enable
  localparam int              SSF_CTL_ODD    = 4;       // odd parity select
  localparam int              SSF_CTL_MP     = 5;       // multiprocessor format
  localparam int              SSF_CTL_STOP2  = 6;       // two stop bits
  localparam int              SSF_CTL_W      = 7;       // control width
  localparam logic [6:0]      SSF_CTRL_RST   = 7'h00;   // control reset value

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  // one finished character from the receive shifter
  typedef struct packed {
    logic       done;       // one-cycle pulse, character complete
    logic [7:0] data;       // received data bits
    logic       stop_bit;   // first sampled stop bit only
    logic       parity_bit; // received parity bit
    logic       mp_bit;     // received multiprocessor bit
  } ssf_rx_evt_s;

  // events from the transmit shifter
  typedef struct packed {
    logic load;     // buffer word moved into tx_shift_reg
    logic last_bit; // final bit of a character shifted out
  } ssf_tx_evt_s;

  // all state of the block
  typedef struct packed {
    logic [7:0]  status; // serial_status
    logic [4:0]  armed;  // per-flag read-as-one memory
    logic [7:0]  tx_buf; // tx_buffer_reg
    logic [7:0]  rx_buf; // rx_buffer_reg
    logic [6:0]  ctrl;   // control bits
    logic [31:0] rdata;  // read data captured in setup
  } ssf_state_s;

endpackage : ssf_pkg

// ===== hdl/ssf_rx_check.sv
`timescale 1ns/100ps
`default_nettype none

module ssf_rx_check
  import ssf_pkg::*;
(
  input  wire ssf_rx_evt_s evt,        // character from the receive shifter
  input  wire logic        sync_mode,  // clocked synchronous mode
  input  wire logic        parity_en,  // parity enabled
  input  wire logic        odd_parity, // odd parity selected
  output logic             frame_err,  // first stop bit sampled low
  output logic             parity_err  // ones count disagrees with setting
);

  // ----------------------------------------------------------------
  // character checks
  // ----------------------------------------------------------------
  // only the first stop bit is handed in, so a low second stop bit
  // can never raise a framing error
  always_comb begin
    frame_err  = !sync_mode && !evt.stop_bit;                  // RQ13 RQ14
    // xor of data and parity is one for odd parity, zero for even
    parity_err = !sync_mode && parity_en &&
                 ((^{evt.data, evt.parity_bit}) != odd_parity); // RQ18
  end

endmodule : ssf_rx_check

`default_nettype wire

// ===== hdl/ssf_serial_status.sv
//
// Behaviour
// [RQ1] status resets to 84 hex, also in standby
// [RQ2] ones ignored; zero clears only after read-as-one
// [RQ3] transmit end and received mp bit read-only
// [RQ4] bit 7 shows transmit buffer moved out
// [RQ5] tx empty cleared by armed zero or write
// [RQ6] tx empty set by reset, standby, disable, load
// [RQ7] rx full set on error-free character
// [RQ8] rx full cleared by reset, standby, zero, read
// [RQ9] errors and receiver disable keep buffer, flag
// [RQ10] overrun set when character ends while full
// [RQ11] overrun keeps old data, halts rx, sync tx
// [RQ12] overrun cleared only by reset, standby, zero
// [RQ13] framing error when stop bit low, async
// [RQ14] only first of two stop bits checked
// [RQ15] framing error stores data, halts, no full
// [RQ16] framing error cleared only reset, standby, zero
// [RQ17] bit 3 flags async parity abort
// [RQ18] parity error on ones count mismatch
// [RQ19] transmit end when last bit, buffer empty
// [RQ20] latch received mp bit in mp format
// [RQ21] bit 0 is transmitted mp bit
// [RQ22] armed bit per flag gates zero clears
//
`timescale 1ns/100ps
`default_nettype none

module ssf_serial_status
  import ssf_pkg::*;
(
  input  wire logic              pclk,        // 125 mhz bus clock
  input  wire logic              presetn,     // async reset, active low
  input  wire logic              psel,        // apb select
  input  wire logic              penable,     // apb access phase
  input  wire logic              pwrite,      // apb direction
  input  wire logic [SSF_AW-1:0] paddr,       // apb byte address
  input  wire logic [31:0]       pwdata,      // apb write data
  output logic      [31:0]       prdata,      // apb read data
  output logic                   pready,      // apb ready
  output logic                   pslverr,     // apb error, unmapped
  input  wire logic              standby,     // standby or module standby
  input  wire ssf_rx_evt_s       rx_evt,      // receive shifter events
  input  wire ssf_tx_evt_s       tx_evt,      // transmit shifter events
  output logic      [7:0]        tx_data,     // word for tx_shift_reg
  output logic                   tx_valid,    // buffer holds valid data
  output logic                   tx_mp_bit,   // mp bit to append
  output logic      [6:0]        ctrl,        // control bits to shifters
  output logic                   rx_halt,     // reception stopped
  output logic                   tx_halt      // transmission stopped
);

  // ----------------------------------------------------------------
  // state and decode
  // ----------------------------------------------------------------
  ssf_state_s st_reg;   // all registers of the block
  ssf_state_s st_next;  // next value of the above
  logic       setup;    // apb setup phase
  logic       acc;      // apb access completing this edge
  logic       wr_acc;   // completing write
  logic       rd_acc;   // completing read
  logic       hit_st;   // status selected
  logic       hit_tx;   // tx buffer selected
  logic       hit_rx;   // rx buffer selected
  logic       hit_ct;   // control selected
  logic       mapped;   // any register selected
  logic       rx_ok;    // character accepted this cycle
  logic       fe;       // framing error of this character
  logic       pe;       // parity error of this character
  logic [4:0] clr;      // armed zero writes per flag
  logic [7:0] s;        // working copy of the status

  assign hit_st = (paddr == SSF_OFF_STATUS);
  assign hit_tx = (paddr == SSF_OFF_TXBUF);
  assign hit_rx = (paddr == SSF_OFF_RXBUF);
  assign hit_ct = (paddr == SSF_OFF_CTRL);
  assign mapped = hit_st | hit_tx | hit_rx | hit_ct;
  assign setup  = psel && !penable;
  assign acc    = psel && penable;
  assign wr_acc = acc && pwrite && mapped;
  assign rd_acc = acc && !pwrite && mapped;

  // ----------------------------------------------------------------
  // character checks
  // ----------------------------------------------------------------
  ssf_rx_check u_check (
    .evt        (rx_evt),
    .sync_mode  (st_reg.ctrl[SSF_CTL_SYNC]),
    .parity_en  (st_reg.ctrl[SSF_CTL_PAREN]),
    .odd_parity (st_reg.ctrl[SSF_CTL_ODD]),
    .frame_err  (fe),
    .parity_err (pe)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // zero wait: read data was captured from flops during setup
  assign pready    = acc;
  assign pslverr   = acc && !mapped;
  assign prdata    = st_reg.rdata;
  assign tx_data   = st_reg.tx_buf;
  assign tx_valid  = !st_reg.status[SSF_POS_TXE];
  assign tx_mp_bit = st_reg.status[SSF_POS_TMP];                 // RQ21
  assign ctrl      = st_reg.ctrl;
  // any error flag stops the receiver until software clears it
  assign rx_halt   = st_reg.status[SSF_POS_OVR] |
                     st_reg.status[SSF_POS_FRM] |
                     st_reg.status[SSF_POS_PAR];                 // RQ11 RQ15
  assign tx_halt   = rx_halt && st_reg.ctrl[SSF_CTL_SYNC];       // RQ11 RQ15
  // a halted or disabled receiver drops the character; nothing moves
  assign rx_ok     = rx_evt.done && st_reg.ctrl[SSF_CTL_RE] && !rx_halt; // RQ9

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    clr     = '0;
    // capture read data in setup so prdata comes from a flop
    if (setup) begin
      st_next.rdata = '0;
      if (hit_st) begin
        st_next.rdata[7:0] = st_reg.status;
      end else if (hit_tx) begin
        st_next.rdata[7:0] = st_reg.tx_buf;
      end else if (hit_rx) begin
        st_next.rdata[7:0] = st_reg.rx_buf;
      end else if (hit_ct) begin
        st_next.rdata[SSF_CTL_W-1:0] = st_reg.ctrl;
      end
    end
    // a completed status read arms each of the five clearable flags it saw as one
    if (rd_acc && hit_st) begin
      st_next.armed = st_reg.armed | st_reg.rdata[7:SSF_POS_FLAG0]; // RQ22
    end
    // zero writes clear armed flags only; ones do nothing
    if (wr_acc && hit_st) begin
      for (int i = 0; i < SSF_NFLAGS; i++) begin
        clr[i] = st_reg.armed[i] && !pwdata[SSF_POS_FLAG0+i];       // RQ2
      end
    end
    s = st_reg.status;
    // read-only bits are never taken from the bus
    if (wr_acc && hit_st) begin
      s[SSF_POS_TMP] = pwdata[SSF_POS_TMP];                         // RQ3 RQ21
    end
    s[7:SSF_POS_FLAG0] = s[7:SSF_POS_FLAG0] & ~clr;                 // RQ12 RQ16
    // clearing the empty flag also ends the transmit-end state
    if (clr[SSF_POS_TXE-SSF_POS_FLAG0]) begin
      s[SSF_POS_TRANSMIT_END_FLAG] = 1'b0;                                       // RQ5
    end
    // a new transmit byte refills the buffer
    if (wr_acc && hit_tx) begin
      st_next.tx_buf  = pwdata[7:0];
      s[SSF_POS_TXE]  = 1'b0;                                       // RQ5
      s[SSF_POS_TRANSMIT_END_FLAG] = 1'b0;
    end
    // reading the receive buffer consumes it
    if (rd_acc && hit_rx) begin
      s[SSF_POS_RXF] = 1'b0;                                        // RQ8
    end
    if (wr_acc && hit_ct) begin
      st_next.ctrl = pwdata[SSF_CTL_W-1:0];
    end
    // hardware sets come last so that they win over clears
    if (tx_evt.last_bit && st_reg.status[SSF_POS_TXE]) begin
      s[SSF_POS_TRANSMIT_END_FLAG] = 1'b1;                                       // RQ19
    end
    if (tx_evt.load) begin
      s[SSF_POS_TXE] = 1'b1;                                        // RQ4 RQ6
    end
    // disabled transmitter holds the buffer empty and ended
    if (!st_reg.ctrl[SSF_CTL_TE]) begin
      s[SSF_POS_TXE]  = 1'b1;                                       // RQ6
      s[SSF_POS_TRANSMIT_END_FLAG] = 1'b1;
    end
    if (rx_ok) begin
      if (!st_reg.ctrl[SSF_CTL_SYNC] && st_reg.ctrl[SSF_CTL_MP]) begin
        s[SSF_POS_RMP] = rx_evt.mp_bit;                             // RQ20
      end
      if (st_reg.status[SSF_POS_RXF]) begin
        // earlier character stays, the new one is dropped
        s[SSF_POS_OVR] = 1'b1;                                      // RQ10 RQ11
      end else begin
        st_next.rx_buf = rx_evt.data;                               // RQ15
        if (fe) begin
          s[SSF_POS_FRM] = 1'b1;                                    // RQ13 RQ15
        end
        if (pe) begin
          s[SSF_POS_PAR] = 1'b1;                                    // RQ17 RQ18
        end
        if (!fe && !pe) begin
          s[SSF_POS_RXF] = 1'b1;                                    // RQ7
        end
      end
    end
    // standby forces the reset pattern; control is left alone
    if (standby) begin
      s             = SSF_STATUS_RST;                               // RQ1
      st_next.armed = '0;
    end
    st_next.status = s;
    // a flag that is low can no longer be armed
    st_next.armed  = st_next.armed & s[7:SSF_POS_FLAG0];            // RQ22
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '{status: SSF_STATUS_RST, ctrl: SSF_CTRL_RST, default: '0}; // RQ1
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // software reads status and sees the overrun flag high
  sequence s_ovr_seen;
    rd_acc && hit_st && st_reg.rdata[SSF_POS_OVR];
  endsequence

  // software then writes zero to that flag; a character in that cycle
  // could set it again, and a set wins over the clear
  sequence s_ovr_zero;
    wr_acc && hit_st && !pwdata[SSF_POS_OVR] && !standby && !rx_evt.done;
  endsequence

  // a bus transfer needs a setup cycle, so the write comes two or more later
  property p_read_then_clear;
    s_ovr_seen ##[2:8] s_ovr_zero |=> !st_reg.status[SSF_POS_OVR];
  endproperty

  a_read_zero_clears: assert property (p_read_then_clear) // RQ2
    else $error("armed zero write did not clear overrun");

  a_unarmed_no_clear: assert property ( // RQ22
    wr_acc && hit_st && !pwdata[SSF_POS_FRM] && st_reg.status[SSF_POS_FRM] &&
    !st_reg.armed[SSF_POS_FRM-SSF_POS_FLAG0] && !standby
    |=> st_reg.status[SSF_POS_FRM])
    else $error("framing flag cleared without a prior read");

  a_standby_init: assert property ( // RQ1
    standby |=> st_reg.status == SSF_STATUS_RST && st_reg.armed == '0)
    else $error("standby did not restore status");

  a_ro_mp_bit: assert property ( // RQ3
    wr_acc && hit_st && !rx_ok && !standby
    |=> st_reg.status[SSF_POS_RMP] == $past(st_reg.status[SSF_POS_RMP]))
    else $error("received mp bit changed by a write");

  a_txbuf_clears: assert property ( // RQ5
    wr_acc && hit_tx && !tx_evt.load && st_reg.ctrl[SSF_CTL_TE] && !standby
    |=> !st_reg.status[SSF_POS_TXE] && tx_data == $past(pwdata[7:0]))
    else $error("transmit buffer write did not clear empty flag");

  a_load_sets_empty: assert property ( // RQ6
    tx_evt.load |=> st_reg.status[SSF_POS_TXE])
    else $error("load did not set empty flag");

  a_good_char_full: assert property ( // RQ7
    rx_ok && !st_reg.status[SSF_POS_RXF] && !fe && !pe && !standby
    |=> st_reg.status[SSF_POS_RXF] && st_reg.rx_buf == $past(rx_evt.data))
    else $error("clean character not stored as full");

  a_overrun_keeps: assert property ( // RQ10
    rx_ok && st_reg.status[SSF_POS_RXF] && !standby
    |=> st_reg.status[SSF_POS_OVR] && $stable(st_reg.rx_buf))
    else $error("overrun not flagged or buffer overwritten");

  a_frame_no_full: assert property ( // RQ15
    rx_ok && fe && !st_reg.status[SSF_POS_RXF] && !standby
    |=> st_reg.status[SSF_POS_FRM] && !st_reg.status[SSF_POS_RXF] &&
        st_reg.rx_buf == $past(rx_evt.data))
    else $error("framing error handled wrongly");

  a_halt_sync_tx: assert property ( // RQ11
    st_reg.status[SSF_POS_OVR] |-> rx_halt && (tx_halt == st_reg.ctrl[SSF_CTL_SYNC]))
    else $error("halt outputs disagree with error flags");

  a_transmit_end_flag_sets: assert property ( // RQ19
    tx_evt.last_bit && st_reg.status[SSF_POS_TXE] |=> st_reg.status[SSF_POS_TRANSMIT_END_FLAG])
    else $error("transmit end not raised");

  a_rxbuf_read_clears: assert property ( // RQ8
    rd_acc && hit_rx && !rx_ok |=> !st_reg.status[SSF_POS_RXF])
    else $error("buffer read left full flag set");

  // a character that arrives while halted must leave the buffer alone
  a_halt_drops_char: assert property ( // RQ11
    rx_evt.done && rx_halt |=> $stable(st_reg.rx_buf))
    else $error("halted receiver stored a character");

  // transmitter off holds both transmit flags high
  a_disable_empty: assert property ( // RQ6
    !st_reg.ctrl[SSF_CTL_TE] |=> st_reg.status[SSF_POS_TXE] && st_reg.status[SSF_POS_TRANSMIT_END_FLAG])
    else $error("disabled transmitter left buffer full");

endmodule : ssf_serial_status

`default_nettype wire

// ===== tb/ssf_remote_node.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// far side: remote node as seen through the shifters
// ----------------------------------------------------------------
module ssf_remote_node
  import ssf_pkg::*;
(
  input  wire logic        pclk,   // bus clock
  output var  ssf_rx_evt_s rx_evt, // finished characters
  output var  ssf_tx_evt_s tx_evt  // transmit shifter events
);
  // idle receive lines start as a fixed pattern, never a stale zero
  initial begin
    rx_evt = '{done: 1'b0, data: 8'h5a, stop_bit: 1'b0, parity_bit: 1'b1, mp_bit: 1'b1};
    tx_evt = '0;
  end

  // one character, done for exactly one cycle
  task send_char(input logic [7:0] d, input logic stp, input logic par, input logic mp);
    @(posedge pclk);
    rx_evt <= '{done: 1'b1, data: d, stop_bit: stp, parity_bit: par, mp_bit: mp};
    @(posedge pclk);
    // released fields show the inverse so a stale capture cannot pass
    rx_evt <= '{done: 1'b0, data: ~d, stop_bit: ~stp, parity_bit: ~par, mp_bit: ~mp};
    // return only once the flags taken at that edge have settled
    @(negedge pclk);
  endtask : send_char

  // one-cycle pulse of load and/or last bit
  task pulse_tx(input logic ld, input logic lb);
    @(posedge pclk);
    tx_evt <= '{load: ld, last_bit: lb};
    @(posedge pclk);
    tx_evt <= '0;
  endtask : pulse_tx
endmodule : ssf_remote_node

`default_nettype wire

// ===== tb/serial_status_flags_test.sv
`timescale 1ns/100ps
`default_nettype none

module serial_status_flags_test
  import ssf_pkg::*;
;
  logic              pclk;      // 125 mhz
  logic              presetn;   // async reset, active low
  logic              psel;      // apb select
  logic              penable;   // apb access phase
  logic              pwrite;    // apb direction
  logic [SSF_AW-1:0] paddr;     // apb address
  logic [31:0]       pwdata;    // apb write data
  logic [31:0]       prdata;    // apb read data
  logic              pready;    // apb ready
  logic              pslverr;   // apb error
  logic              standby;   // standby request
  ssf_rx_evt_s       rx_evt;    // from the remote node
  ssf_tx_evt_s       tx_evt;    // from the remote node
  logic [7:0]        tx_data;   // word to shifter
  logic              tx_valid;  // buffer valid
  logic              tx_mp_bit; // appended mp bit
  logic [6:0]        ctrl;      // control bits
  logic              rx_halt;   // reception stopped
  logic              tx_halt;   // transmission stopped
  logic [31:0]       rdat;      // last read data
  logic              rerr;      // last pslverr
  int                n_errors;  // mismatches
  int                n_compared; // comparisons

  always #4 pclk = ~pclk;

  ssf_serial_status dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .standby(standby), .rx_evt(rx_evt), .tx_evt(tx_evt),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_mp_bit(tx_mp_bit), .ctrl(ctrl),
    .rx_halt(rx_halt), .tx_halt(tx_halt));

  ssf_remote_node node_u (.pclk(pclk), .rx_evt(rx_evt), .tx_evt(tx_evt));

  // ----------------------------------------------------------------
  // compare and bus helpers
  // ----------------------------------------------------------------
  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_bit

  // one apb transfer; request held until pready is seen high at an edge
  task apb(input logic w, input logic [SSF_AW-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle limit here; only the watchdog ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [SSF_AW-1:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr

  task rd_chk(input logic [SSF_AW-1:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0);
    chk_word(rdat, {24'h0, exp});
  endtask : rd_chk

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // writing ones is ignored; bit 0 alone is writable
  task t_write_masks;
    wr(SSF_OFF_CTRL, 8'h03);
    wr(SSF_OFF_STATUS, 8'hff);
    rd_chk(SSF_OFF_STATUS, 8'h85);
    chk_bit(tx_mp_bit, 1'b1);
    wr(SSF_OFF_STATUS, 8'h82);
    rd_chk(SSF_OFF_STATUS, 8'h84);
  endtask : t_write_masks

  // buffer write, load, last bit, then an armed zero clear
  task t_transmit;
    wr(SSF_OFF_TXBUF, 8'h5a);
    rd_chk(SSF_OFF_STATUS, 8'h00);
    chk_word({24'h0, tx_data}, 32'h5a);
    chk_bit(tx_valid, 1'b1);
    node_u.pulse_tx(1'b1, 1'b0);
    rd_chk(SSF_OFF_STATUS, 8'h80);
    node_u.pulse_tx(1'b0, 1'b1);
    rd_chk(SSF_OFF_STATUS, 8'h84);
    wr(SSF_OFF_STATUS, 8'h00);
    rd_chk(SSF_OFF_STATUS, 8'h00);
    node_u.pulse_tx(1'b1, 1'b1);
    node_u.pulse_tx(1'b0, 1'b1);
    rd_chk(SSF_OFF_STATUS, 8'h84);
    // disabling the transmitter empties a refilled buffer
    wr(SSF_OFF_TXBUF, 8'hc3);
    rd_chk(SSF_OFF_STATUS, 8'h00);
    wr(SSF_OFF_CTRL, 8'h02);
    rd_chk(SSF_OFF_STATUS, 8'h84);
    chk_word({25'h0, ctrl}, 32'h02);
    chk_bit(tx_valid, 1'b0);
    wr(SSF_OFF_CTRL, 8'h03);
  endtask : t_transmit

  // second character while full; halted receiver drops a third; armed zero clears overrun
  task t_overrun;
    node_u.send_char(8'h3c, 1'b1, 1'b0, 1'b0);
    rd_chk(SSF_OFF_STATUS, 8'hc4);
    node_u.send_char(8'ha5, 1'b1, 1'b0, 1'b0);
    chk_bit(rx_halt, 1'b1);
    rd_chk(SSF_OFF_RXBUF, 8'h3c);
    rd_chk(SSF_OFF_STATUS, 8'ha4);
    node_u.send_char(8'h11, 1'b1, 1'b0, 1'b0);
    rd_chk(SSF_OFF_RXBUF, 8'h3c);
    wr(SSF_OFF_CTRL, 8'h01);
    rd_chk(SSF_OFF_STATUS, 8'ha4);
    wr(SSF_OFF_CTRL, 8'h03);
    wr(SSF_OFF_STATUS, 8'h80);
    rd_chk(SSF_OFF_STATUS, 8'h84);
    chk_bit(rx_halt, 1'b0);
  endtask : t_overrun

  // low stop bit stores data without full, halts until cleared
  task t_framing;
    node_u.send_char(8'h96, 1'b0, 1'b0, 1'b0);
    // zero written before any read must leave the flag set
    wr(SSF_OFF_STATUS, 8'h80);
    rd_chk(SSF_OFF_STATUS, 8'h94);
    rd_chk(SSF_OFF_RXBUF, 8'h96);
    chk_bit(rx_halt, 1'b1);
    wr(SSF_OFF_STATUS, 8'h80);
    rd_chk(SSF_OFF_STATUS, 8'h84);
  endtask : t_framing

  // even parity good and bad characters, then a good odd parity character
  task t_parity;
    wr(SSF_OFF_CTRL, 8'h0b);
    node_u.send_char(8'h03, 1'b1, 1'b0, 1'b0);
    rd_chk(SSF_OFF_STATUS, 8'hc4);
    rd_chk(SSF_OFF_RXBUF, 8'h03);
    node_u.send_char(8'h01, 1'b1, 1'b0, 1'b0);
    rd_chk(SSF_OFF_STATUS, 8'h8c);
    rd_chk(SSF_OFF_RXBUF, 8'h01);
    wr(SSF_OFF_STATUS, 8'h80);
    wr(SSF_OFF_CTRL, 8'h1b);
    node_u.send_char(8'h01, 1'b1, 1'b0, 1'b0);
    rd_chk(SSF_OFF_STATUS, 8'hc4);
    wr(SSF_OFF_STATUS, 8'h80);
    rd_chk(SSF_OFF_STATUS, 8'h84);
  endtask : t_parity

  // received mp bit latched and protected from writes
  task t_multiproc;
    wr(SSF_OFF_CTRL, 8'h23);
    node_u.send_char(8'h40, 1'b1, 1'b0, 1'b1);
    rd_chk(SSF_OFF_STATUS, 8'hc6);
    rd_chk(SSF_OFF_RXBUF, 8'h40);
    wr(SSF_OFF_STATUS, 8'h80);
    rd_chk(SSF_OFF_STATUS, 8'h86);
  endtask : t_multiproc

  // sync overrun halts transmit too; standby restores reset value
  task t_sync_standby;
    wr(SSF_OFF_CTRL, 8'h07);
    node_u.send_char(8'h12, 1'b1, 1'b0, 1'b0);
    node_u.send_char(8'h34, 1'b1, 1'b0, 1'b0);
    chk_bit(tx_halt, 1'b1);
    @(posedge pclk);
    standby <= 1'b1;
    repeat (2) @(posedge pclk);
    standby <= 1'b0;
    rd_chk(SSF_OFF_STATUS, 8'h84);
    chk_bit(tx_halt, 1'b0);
    rd_chk(SSF_OFF_RXBUF, 8'h12);
    apb(1'b0, 12'h010, 32'h0);
    chk_bit(rerr, 1'b1);
    chk_word(rdat, 32'h0);
  endtask : t_sync_standby

  // ----------------------------------------------------------------
  // verdict, watchdog and main sequence
  // ----------------------------------------------------------------
  task give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // whole run is about two hundred cycles; this is far beyond it
  initial begin
    #200000;
    n_errors++;
    give_verdict;
  end

  initial begin
    pclk       = 1'b0;
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = '0;
    pwdata     = '0;
    standby    = 1'b0;
    n_errors   = 0;
    n_compared = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(SSF_OFF_STATUS, 8'h84);
    t_write_masks;
    t_transmit;
    t_overrun;
    t_framing;
    t_parity;
    t_multiproc;
    t_sync_standby;
    give_verdict;
  end
endmodule : serial_status_flags_test

`default_nettype wire
